// >>> design/epm_pkg.sv
// Package for the EEPROM pin multiplexer with bus-width strap
package epm_pkg;
    // ========================================
    // Register map
    localparam logic [3:0] EPM_OFF_CTRL   = 4'h0;
    localparam logic [3:0] EPM_OFF_STATUS = 4'h4;
    localparam logic [3:0] EPM_OFF_EEP    = 4'h8;
    localparam int EPM_ADDR_W = 4;
    // Pin mode field, two bits per pin
    localparam int EPM_DATA_MODE_LSB = 0;
    localparam int EPM_CLK_MODE_LSB  = 2;
    localparam int EPM_GENERAL_OUTPUT_THREE_BIT      = 4;
    localparam int EPM_GENERAL_OUTPUT_FOUR_BIT      = 5;
    localparam int EPM_MDIX_BIT      = 6;
    localparam int EPM_STRAP_BIT     = 0;
    localparam int EPM_W32_BIT       = 1;
    localparam int EPM_SWAP_BIT      = 2;
    localparam int EPM_EE_CS_BIT     = 0;
    localparam int EPM_EE_CLK_BIT    = 1;
    localparam int EPM_EE_DO_BIT     = 2;
    localparam int EPM_EE_OE_BIT     = 3;
    localparam int EPM_EE_DI_BIT     = 4;
    localparam logic [6:0] EPM_CTRL_RST  = 7'h00;
    localparam logic [3:0] EPM_EEP_RST   = 4'h0;
    localparam logic [31:0] EPM_RDATA_RST = 32'h0000_0000;
    localparam logic       EPM_STRAP_RST = 1'h0;
    localparam logic       EPM_ARMED_RST = 1'h1;
    // Field widths
    localparam int EPM_CTRL_W = 7;
    localparam int EPM_EEP_W  = 4;
    localparam int EPM_MODE_W = 2;

    typedef enum logic [1:0] {
        EPM_MODE_EEPROM,
        EPM_MODE_GPO,
        EPM_MODE_MON_A,
        EPM_MODE_MON_B
    } epm_mode_t;

    typedef struct packed {
        logic tx_en;
        logic tx_clk;
        logic rx_dv;
        logic rx_clk;
    } epm_mii_t;

    typedef struct packed {
        logic i;
        logic o;
        logic oe;
    } epm_pin_t;
endpackage

// >>> design/epm_pin_mux.sv
// EEPROM pin multiplexer, bus-width strap and pair swap
`timescale 1ns/1ps
`default_nettype none
module epm_pin_mux
    import epm_pkg::*;
(
    input  wire logic                  clk_i,
    input  wire logic                  sys_rst_i,
    input  wire logic [EPM_ADDR_W-1:0] addr_i,
    input  wire logic [31:0]           wdata_i,
    input  wire logic                  wr_i,
    input  wire logic                  rd_i,
    output logic      [31:0]           rdata_o,
    input  wire epm_mii_t              mii_i,
    input  wire logic                  mdix_detect_i,
    input  wire logic                  eeprom_data_line_i,
    output logic                       eeprom_data_line_o,
    output logic                       eeprom_data_line_oe_o,
    output logic                       eeprom_serial_clock_o,
    output logic                       eeprom_chip_select_o,
    output logic                       bus_width_32_o,
    output logic                       pair_swap_o
);
    // ========================================
    // Register state
    logic [EPM_CTRL_W-1:0] ctrl_r;
    logic [EPM_EEP_W-1:0]  eep_r;
    logic [31:0]           rdata_r;
    logic                  strap_r;
    logic                  strap_armed_r;

    // ========================================
    // Register bus decode
    wire                  hit_ctrl;
    wire                  hit_status;
    wire                  hit_eep;
    wire                  wr_ctrl;
    wire                  wr_eep;
    wire [EPM_CTRL_W-1:0] ctrl_nxt;
    wire [EPM_EEP_W-1:0]  eep_nxt;

    assign hit_ctrl   = (addr_i == EPM_OFF_CTRL);
    assign hit_status = (addr_i == EPM_OFF_STATUS);
    assign hit_eep    = (addr_i == EPM_OFF_EEP);
    // Unmapped offsets ignore writes
    assign wr_ctrl    = wr_i && hit_ctrl;
    assign wr_eep     = wr_i && hit_eep;
    assign ctrl_nxt   = wr_ctrl ? wdata_i[EPM_CTRL_W-1:0] : ctrl_r;
    assign eep_nxt    = wr_eep ? wdata_i[EPM_EEP_W-1:0] : eep_r;

    // ========================================
    // Control fields
    epm_mode_t data_mode;
    epm_mode_t clk_mode;
    wire       general_output_three_val;
    wire       general_output_four_val;
    wire       force_swap;
    wire       ee_cs;
    wire       ee_clk;
    wire       ee_do;
    wire       ee_oe;

    assign data_mode  = epm_mode_t'(ctrl_r[EPM_DATA_MODE_LSB +: EPM_MODE_W]);
    assign clk_mode   = epm_mode_t'(ctrl_r[EPM_CLK_MODE_LSB +: EPM_MODE_W]);
    assign general_output_three_val   = ctrl_r[EPM_GENERAL_OUTPUT_THREE_BIT];
    assign general_output_four_val   = ctrl_r[EPM_GENERAL_OUTPUT_FOUR_BIT];
    assign force_swap = ctrl_r[EPM_MDIX_BIT];
    assign ee_cs      = eep_r[EPM_EE_CS_BIT];
    assign ee_clk     = eep_r[EPM_EE_CLK_BIT];
    assign ee_do      = eep_r[EPM_EE_DO_BIT];
    assign ee_oe      = eep_r[EPM_EE_OE_BIT];

    // ========================================
    // Mode flags
    wire data_ee;
    wire data_gpo;
    wire data_tx_en_sel;
    wire clk_ee;
    wire clk_gpo;
    wire clk_rx_dv_sel;
    wire both_ee;

    assign data_ee        = (data_mode == EPM_MODE_EEPROM);
    assign data_gpo       = (data_mode == EPM_MODE_GPO);
    assign data_tx_en_sel = (data_mode == EPM_MODE_MON_A);
    assign clk_ee         = (clk_mode == EPM_MODE_EEPROM);
    assign clk_gpo        = (clk_mode == EPM_MODE_GPO);
    assign clk_rx_dv_sel  = (clk_mode == EPM_MODE_MON_A);
    // Memory is reachable only when both pins are its own
    assign both_ee        = data_ee && clk_ee;

    // ========================================
    // Monitor taps
    wire tx_mon;
    wire rx_mon;

    assign tx_mon = data_tx_en_sel ? mii_i.tx_en : mii_i.tx_clk;
    assign rx_mon = clk_rx_dv_sel ? mii_i.rx_dv : mii_i.rx_clk;

    // ========================================
    // Data pin
    wire data_value_out;

    assign data_value_out = data_gpo ? general_output_three_val : tx_mon;
    assign eeprom_data_line_o = data_ee ? ee_do : data_value_out;
    assign eeprom_data_line_oe_o = data_ee ? ee_oe : 1'b1;

    // ========================================
    // Clock pin and chip select
    wire clk_value_out;

    assign clk_value_out = clk_gpo ? general_output_four_val : rx_mon;
    assign eeprom_serial_clock_o = clk_ee ? ee_clk : clk_value_out;
    assign eeprom_chip_select_o = both_ee && ee_cs;

    // ========================================
    // Strap, width and pair swap
    wire strap_nxt;
    wire swap;

    // strap caught on first edge after release
    assign strap_nxt = strap_armed_r ? eeprom_data_line_i : strap_r;
    assign bus_width_32_o = strap_r;
    assign swap = mdix_detect_i || force_swap;
    assign pair_swap_o = swap;

    // ========================================
    // Read path
    wire [31:0] status_w;
    wire [31:0] eep_w;
    wire [31:0] rd_sel;
    wire [31:0] rdata_nxt;

    // Swap, width and strap from bit two down
    assign status_w  = 32'({swap, strap_r, strap_r});
    // Pin level rides above the memory control bits
    assign eep_w     = 32'({eeprom_data_line_i, eep_r});
    assign rd_sel    = hit_ctrl ? 32'(ctrl_r)
                     : hit_status ? status_w
                     : hit_eep ? eep_w
                     : 32'h0000_0000;
    // Zero outside the read cycle keeps the bus quiet
    assign rdata_nxt = rd_i ? rd_sel : EPM_RDATA_RST;
    assign rdata_o   = rdata_r;

    // ========================================
    // Control register
    // EEPROM mode default
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            ctrl_r <= EPM_CTRL_RST;
        end
        else
        begin
            ctrl_r <= ctrl_nxt;
        end
    end

    // ========================================
    // Memory control register
    // Output enable off at reset, so the strap is readable
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            eep_r <= EPM_EEP_RST;
        end
        else
        begin
            eep_r <= eep_nxt;
        end
    end

    // ========================================
    // Read data register
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            rdata_r <= EPM_RDATA_RST;
        end
        else
        begin
            rdata_r <= rdata_nxt;
        end
    end

    // ========================================
    // Strap capture
    // Pin must be steady at the first edge after release
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            strap_r <= EPM_STRAP_RST;
        end
        else
        begin
            strap_r <= strap_nxt;
        end
    end

    // One shot, so later pin activity never moves the width
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            strap_armed_r <= EPM_ARMED_RST;
        end
        else
        begin
            strap_armed_r <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// >>> tb/epm_pin_mux_checker.sv
// Port checker for the EEPROM pin multiplexer
`timescale 1ns/1ps
`default_nettype none
module epm_pin_mux_checker (
    input wire logic        clk_i,
    input wire logic        sys_rst_i,
    input wire logic        rd_i,
    input wire logic [31:0] rdata_o,
    input wire logic        mdix_detect_i,
    input wire logic        eeprom_data_line_i,
    input wire logic        eeprom_data_line_oe_o,
    input wire logic        bus_width_32_o,
    input wire logic        eeprom_serial_clock_o,
    input wire logic        eeprom_chip_select_o,
    input wire logic        pair_swap_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    // ====
    // Strap capture and hold
    property p_latch;
        $past(sys_rst_i) |=> bus_width_32_o == $past(eeprom_data_line_i);
    endproperty
    a_latch: assert property (p_latch) else $error("strap wrong");
    property p_hold;
        !$past(sys_rst_i, 2) |-> $stable(bus_width_32_o);
    endproperty
    a_hold: assert property (p_hold) else $error("strap moved");
    property p_idle;
        $past(sys_rst_i) |-> !eeprom_data_line_oe_o;
    endproperty
    a_idle: assert property (p_idle) else $error("pin driven");
    // Read data only in the cycle after a read
    property p_rd;
        !$past(rd_i) |-> rdata_o == 32'h0;
    endproperty
    a_rd: assert property (p_rd) else $error("stray read data");
    // Memory pins quiet after reset
    property p_cs_idle;
        $past(sys_rst_i) |-> !eeprom_chip_select_o;
    endproperty
    a_cs_idle: assert property (p_cs_idle) else $error("select on");
    property p_clk_idle;
        $past(sys_rst_i) |-> !eeprom_serial_clock_o;
    endproperty
    a_clk_idle: assert property (p_clk_idle) else $error("clock on");
    // Detected reversal always swaps
    property p_swap;
        mdix_detect_i |-> pair_swap_o;
    endproperty
    a_swap: assert property (p_swap) else $error("no swap");
endmodule
bind epm_pin_mux epm_pin_mux_checker chk_u (.clk_i, .sys_rst_i, .rd_i,
    .rdata_o, .mdix_detect_i, .eeprom_data_line_i, .eeprom_data_line_oe_o,
    .bus_width_32_o, .eeprom_serial_clock_o, .eeprom_chip_select_o,
    .pair_swap_o);
`default_nettype wire

// >>> tb/epm_eeprom_model.sv
// Serial memory model on the far side of the shared pins
`timescale 1ns/1ps
`default_nettype none
module epm_eeprom_model (
    input  wire logic cs_i,
    input  wire logic sck_i,
    input  wire logic dio_i,
    output logic      dio_o,
    output logic      dio_oe_o
);
    logic [3:0] sr_r;
    // Deselected memory forgets, so no stale bit reaches the line
    always_ff @(posedge sck_i or negedge cs_i)
        if (!cs_i) sr_r <= 4'h0;
        else sr_r <= {sr_r[2:0], dio_i};
    assign dio_oe_o = cs_i & sr_r[3];
    assign dio_o    = ~sr_r[0];
endmodule
`default_nettype wire

// >>> tb/epm_pin_mux_tb.sv
// Self-checking bench for the EEPROM pin multiplexer
`timescale 1ns/1ps
`default_nettype none
module epm_pin_mux_tb import epm_pkg::*; ;
    logic clk_i = 0, sys_rst_i = 1, wr_i = 0, rd_i = 0, mdix = 0, strap = 1;
    logic [3:0] addr_i = 4'h0;
    logic [31:0] wdata_i = 32'h0, rdata_o;
    epm_mii_t mii = '0;
    logic d_o, d_oe, sck, cs, w32, swp, m_o, m_oe, pin;
    int err_count = 0, checks_done = 0, cyc = 0;
    // Strap resistor wins only when nobody drives
    assign pin = d_oe ? d_o : m_oe ? m_o : strap;
    epm_pin_mux dut_u (.clk_i, .sys_rst_i, .addr_i, .wdata_i, .wr_i, .rd_i,
        .rdata_o, .mii_i(mii), .mdix_detect_i(mdix), .eeprom_data_line_i(pin),
        .eeprom_data_line_o(d_o), .eeprom_data_line_oe_o(d_oe),
        .eeprom_serial_clock_o(sck), .eeprom_chip_select_o(cs),
        .bus_width_32_o(w32), .pair_swap_o(swp));
    epm_eeprom_model mem_u (.cs_i(cs), .sck_i(sck), .dio_i(pin), .dio_o(m_o),
        .dio_oe_o(m_oe));
    initial forever #4 clk_i = ~clk_i;
    always @(posedge clk_i) if (++cyc == 2000) wrap_up(1'b1);
    // ====
    // Bus tasks and compare
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e)
        begin
            err_count++;
            $display("Error at %0t seen %0h expected %0h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        {addr_i, wdata_i, wr_i} <= {a, d, 1'b1};
        @(posedge clk_i);
        wr_i <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge clk_i);
        {addr_i, rd_i} <= {a, 1'b1};
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 chk(rdata_o, e);
    endtask
    task automatic wrap_up(input bit late);
        err_count += late;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial
    begin
        for (int s = 1; s >= 0; s--)
        begin
            strap = s[0];
            @(posedge clk_i);
            sys_rst_i <= 1'b1;
            repeat (12) @(posedge clk_i);
            sys_rst_i <= 1'b0;
            rd(EPM_OFF_STATUS, {30'h0, s[0], s[0]});
            chk(w32, s[0]);
        end
        rd(EPM_OFF_CTRL, 32'h0);
        $display("strap test done");
        wr(EPM_OFF_EEP, 32'h07);
        rd(EPM_OFF_EEP, 32'h07);
        wr(EPM_OFF_EEP, 32'h0F);
        chk({cs, sck, d_oe, pin}, 4'hF);
        rd(EPM_OFF_EEP, 32'h1F);
        wr(EPM_OFF_CTRL, 32'h15);
        chk({cs, sck, d_oe, pin}, 4'h3);
        wr(EPM_OFF_CTRL, 32'h21);
        chk({cs, sck, d_oe, pin}, 4'h6);
        wr(EPM_OFF_CTRL, 32'h24);
        chk({cs, sck, d_oe, pin}, 4'h7);
        for (int m = 2; m < 4; m++)
        begin
            wr(EPM_OFF_CTRL, 32'(m * 5));
            for (int v = 0; v < 16; v++)
            begin
                @(posedge clk_i);
                mii <= epm_mii_t'(v[3:0]);
                #1 chk({cs, pin, sck}, {1'b0, v[5 - m], v[3 - m]});
            end
        end
        $display("pin mode test done");
        @(posedge clk_i);
        mdix <= 1'b1;
        #1 chk(swp, 1'b1);
        @(posedge clk_i);
        mdix <= 1'b0;
        wr(EPM_OFF_CTRL, 32'h40);
        chk(swp, 1'b1);
        rd(EPM_OFF_STATUS, 32'h4);
        wr(4'hC, 32'h15);
        rd(4'hC, 32'h0);
        rd(EPM_OFF_CTRL, 32'h40);
        $display("swap and map test done");
        wrap_up(1'b0);
    end
endmodule
`default_nettype wire
